// [rtl/dual_dac_sample_port.sv]
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dac_port_defs.svh"
module dual_dac_sample_port #(
	parameter int CFG_CYCLES = `CFG_CYCLES
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  link_up_pin,
	input  wire logic                  sample_valid,
	input  wire dac_port_pkg::lanes_t  chan0_sample_lanes,
	input  wire dac_port_pkg::lanes_t  chan1_sample_lanes,
	output logic                       word_clock,
	output logic                       double_rate_clock,
	output logic                       output_link_ready,
	output logic                       config_done,
	output logic [31:0]                error_word,
	output dac_port_pkg::frame_t       conv_frame,
	output logic                       conv_frame_valid,
	output logic                       conv_dual_mode,
	output logic                       conv_isinc_en,
	output logic                       clk_src_ext,
	output logic [`TRIM_W-1:0]         phase_trim,
	output logic                       irq
);

	localparam int CW = $clog2(CFG_CYCLES + 1);

	logic                     word_tick;
	// Bus state
	logic                     awready_reg, awready_next;
	logic                     aw_held_reg, aw_held_next;
	logic [7:0]               awaddr_reg, awaddr_next;
	logic                     wready_reg, wready_next;
	logic                     w_held_reg, w_held_next;
	logic [31:0]              wdata_reg, wdata_next;
	logic [3:0]               wstrb_reg, wstrb_next;
	logic                     bvalid_reg, bvalid_next;
	logic [1:0]               bresp_reg, bresp_next;
	logic                     arready_reg, arready_next;
	logic                     rvalid_reg, rvalid_next;
	logic [31:0]              rdata_reg, rdata_next;
	logic [1:0]               rresp_reg, rresp_next;
	logic                     do_write;
	logic [7:0]               wr_addr;
	logic [31:0]              rd_word;
	logic                     rd_hit;
	// Control state
	dac_port_pkg::ctrl_t      ctrl_reg, ctrl_next;
	logic [`TRIM_W-1:0]       trim_reg, trim_next;
	logic [`IRQ_W-1:0]        istat_reg, istat_next;
	logic [`IRQ_W-1:0]        imask_reg, imask_next;
	logic [31:0]              err_reg, err_next;
	dac_port_pkg::cfg_state_t state_reg, state_next;
	logic [CW-1:0]            cnt_reg, cnt_next;
	logic                     done_reg, done_next;
	logic                     ready_reg, ready_next;
	logic                     irq_reg, irq_next;
	logic                     link_meta_reg, link_sync_reg;
	logic [`IRQ_W-1:0]        events;
	logic [31:0]              ctrl_wr, trim_wr, mask_wr;
	// Datapath state
	dac_port_pkg::frame_t     frame_reg, frame_next;
	logic                     fvalid_reg, fvalid_next;
	logic [31:0]              count_reg, count_next;
	logic                     accept;

	word_clock_gen u_clk (
		.aclk              (aclk),
		.aresetn           (aresetn),
		.ce                (ce),
		.word_clock        (word_clock),
		.double_rate_clock (double_rate_clock),
		.word_tick         (word_tick)
	);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Register read mux
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case ({s_axi_araddr[7:2], 2'b00})
			`A_CTRL: rd_word = {27'h0, ctrl_reg};
			`A_TRIM: rd_word = {20'h0, trim_reg};
			`A_STAT: rd_word = {29'h0, link_sync_reg, done_reg, ready_reg};
			`A_IRQ_STAT: rd_word = {29'h0, istat_reg};
			`A_IRQ_MASK: rd_word = {29'h0, imask_reg};
			`A_ERR: rd_word = err_reg;
			`A_COUNT: rd_word = count_reg;
			default: rd_hit = 1'b0;
		endcase
	end

	// AXI4-Lite slave handshakes
	always_comb begin
		awready_next = awready_reg;
		aw_held_next = aw_held_reg;
		awaddr_next  = awaddr_reg;
		wready_next  = wready_reg;
		w_held_next  = w_held_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		arready_next = arready_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		do_write     = aw_held_reg && w_held_reg && !bvalid_reg;
		wr_addr      = {awaddr_reg[7:2], 2'b00};
		if (s_axi_awvalid && awready_reg) begin
			aw_held_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
			awready_next = 1'b0;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_held_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
			wready_next = 1'b0;
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = `RESP_OKAY;
			if (wr_addr != `A_CTRL && wr_addr != `A_TRIM &&
				wr_addr != `A_IRQ_STAT && wr_addr != `A_IRQ_MASK) begin
				bresp_next = `RESP_SLVERR;
			end
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next  = 1'b0;
			awready_next = 1'b1;
			wready_next  = 1'b1;
		end
		if (s_axi_arvalid && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next  = 1'b1;
			rdata_next   = rd_word;
			rresp_next   = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next  = 1'b0;
			arready_next = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			aw_held_reg <= 1'b0;
			awaddr_reg  <= 8'h00;
			wready_reg  <= 1'b1;
			w_held_reg  <= 1'b0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `RESP_OKAY;
		end else if (ce) begin
			awready_reg <= awready_next;
			aw_held_reg <= aw_held_next;
			awaddr_reg  <= awaddr_next;
			wready_reg  <= wready_next;
			w_held_reg  <= w_held_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// Control, configuration sequence, errors and interrupts
	always_comb begin
		ctrl_next         = ctrl_reg;
		ctrl_next.restart = 1'b0;
		trim_next         = trim_reg;
		istat_next        = istat_reg;
		imask_next        = imask_reg;
		err_next          = err_reg;
		state_next        = state_reg;
		cnt_next          = cnt_reg;
		done_next         = done_reg;
		events            = '0;
		ctrl_wr           = merge({27'h0, ctrl_reg}, wdata_reg, wstrb_reg);
		trim_wr           = merge({20'h0, trim_reg}, wdata_reg, wstrb_reg);
		mask_wr           = merge({29'h0, imask_reg}, wdata_reg, wstrb_reg);
		events[`IRQ_DROP] = word_tick && sample_valid && !ready_reg;
		events[`IRQ_DONE] = state_reg == dac_port_pkg::CFG_WAIT &&
			cnt_reg == '0;
		events[`IRQ_LOST] = ready_reg && !link_sync_reg;
		case (state_reg)
			dac_port_pkg::CFG_START: begin
				cnt_next   = CW'(CFG_CYCLES - 1);
				done_next  = 1'b0;
				state_next = dac_port_pkg::CFG_WAIT;
			end
			dac_port_pkg::CFG_WAIT: begin
				if (cnt_reg == '0) begin
					done_next  = 1'b1;
					state_next = dac_port_pkg::CFG_DONE;
				end else begin
					cnt_next = cnt_reg - CW'(1);
				end
			end
			dac_port_pkg::CFG_DONE: done_next = 1'b1;
			default: state_next = dac_port_pkg::CFG_START;
		endcase
		if (err_reg == `ERR_NONE) begin
			if (events[`IRQ_LOST]) begin
				err_next = `ERR_LOST;
			end else if (events[`IRQ_DROP]) begin
				err_next = `ERR_DROP;
			end
		end
		if (do_write && wr_addr == `A_CTRL) begin
			ctrl_next = ctrl_wr[$bits(ctrl_next)-1:0];
			if (ctrl_next.dual != ctrl_reg.dual ||
				ctrl_next.clk_ext != ctrl_reg.clk_ext) begin
				state_next = dac_port_pkg::CFG_START;
				done_next  = 1'b0;
			end
		end
		if (do_write && wr_addr == `A_TRIM) begin
			trim_next = trim_wr[`TRIM_W-1:0];
		end
		if (do_write && wr_addr == `A_IRQ_MASK) begin
			imask_next = mask_wr[`IRQ_W-1:0];
		end
		if (do_write && wr_addr == `A_IRQ_STAT && wstrb_reg[0]) begin
			istat_next = istat_reg & ~wdata_reg[`IRQ_W-1:0];
		end
		istat_next = istat_next | events;
		if (ctrl_reg.restart) begin
			ctrl_next  = `CTRL_RST;
			trim_next  = `TRIM_MIN;
			err_next   = `ERR_NONE;
			state_next = dac_port_pkg::CFG_START;
			done_next  = 1'b0;
		end
		ready_next = done_reg && link_sync_reg && ctrl_reg.link_en;
		irq_next   = |(istat_reg & imask_reg);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg      <= `CTRL_RST;
			trim_reg      <= `TRIM_MIN;
			istat_reg     <= '0;
			imask_reg     <= '0;
			err_reg       <= `ERR_NONE;
			state_reg     <= dac_port_pkg::CFG_START;
			cnt_reg       <= '0;
			done_reg      <= 1'b0;
			ready_reg     <= 1'b0;
			irq_reg       <= 1'b0;
			link_meta_reg <= 1'b0;
			link_sync_reg <= 1'b0;
		end else if (ce) begin
			ctrl_reg      <= ctrl_next;
			trim_reg      <= trim_next;
			istat_reg     <= istat_next;
			imask_reg     <= imask_next;
			err_reg       <= err_next;
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			done_reg      <= done_next;
			ready_reg     <= ready_next;
			irq_reg       <= irq_next;
			link_meta_reg <= link_up_pin;
			link_sync_reg <= link_meta_reg;
		end
	end

	// Sample sets are taken once per word clock, only while ready
	always_comb begin
		accept      = word_tick && sample_valid && ready_reg;
		frame_next  = frame_reg;
		fvalid_next = accept;
		count_next  = count_reg;
		if (accept) begin
			frame_next.chan0 = chan0_sample_lanes;
			frame_next.chan1 = chan1_sample_lanes;
			count_next       = count_reg + 32'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_reg  <= '0;
			fvalid_reg <= 1'b0;
			count_reg  <= 32'h0000_0000;
		end else if (ce) begin
			frame_reg  <= frame_next;
			fvalid_reg <= fvalid_next;
			count_reg  <= count_next;
		end
	end

	assign s_axi_awready     = awready_reg;
	assign s_axi_wready      = wready_reg;
	assign s_axi_bvalid      = bvalid_reg;
	assign s_axi_bresp       = bresp_reg;
	assign s_axi_arready     = arready_reg;
	assign s_axi_rvalid      = rvalid_reg;
	assign s_axi_rdata       = rdata_reg;
	assign s_axi_rresp       = rresp_reg;
	assign output_link_ready = ready_reg;
	assign config_done       = done_reg;
	assign error_word        = err_reg;
	assign conv_frame        = frame_reg;
	assign conv_frame_valid  = fvalid_reg;
	assign conv_dual_mode    = ctrl_reg.dual;
	assign conv_isinc_en     = ctrl_reg.isinc;
	assign clk_src_ext       = ctrl_reg.clk_ext;
	assign phase_trim        = trim_reg;
	assign irq               = irq_reg;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_reset_conv_mode: assert property ($rose(aresetn) |->
		ctrl_reg.dual && !ctrl_reg.isinc)
		else $error("converter mode not at default after reset");
	a_reset_clk_src: assert property ($rose(aresetn) |->
		!ctrl_reg.clk_ext)
		else $error("clock source not internal after reset");
	a_reset_trim_min: assert property ($rose(aresetn) |->
		trim_reg == `TRIM_MIN)
		else $error("phase trim not minimum after reset");
	a_restart_defaults: assert property (ctrl_reg.restart && ce |=>
		ctrl_reg == `CTRL_RST && trim_reg == `TRIM_MIN)
		else $error("restart did not restore defaults");
	a_double_rate: assert property ($changed(word_clock) |->
		$fell(double_rate_clock))
		else $error("word clock not locked to double rate clock");
	a_ready_cause: assert property ($rose(output_link_ready) |->
		$past(done_reg) && $past(link_sync_reg))
		else $error("ready raised without link and configuration");
	a_accept_ready: assert property (conv_frame_valid |->
		$past(ready_reg) && $past(word_tick))
		else $error("sample set taken while not ready");
	a_error_hold: assert property (err_reg != `ERR_NONE &&
		!ctrl_reg.restart |=> $stable(err_reg))
		else $error("error word changed without restart");
	a_config_finish: assert property (state_reg ==
		dac_port_pkg::CFG_WAIT && cnt_reg == '0 && ce && !ctrl_reg.restart &&
		!do_write |=> config_done)
		else $error("config done missing after configuration time");
	a_config_cause: assert property (config_done |->
		state_reg == dac_port_pkg::CFG_DONE)
		else $error("config done outside finished state");

endmodule

// [common/dac_port_defs.svh]
// Functional notes
// - Reset or restart restores dual-channel 3.2 GS/s mode, inverse sinc off.
// - Reset or restart selects internal clock locked to backplane reference.
// - Reset or restart sets the phase trim value to its minimum.
// - Device drives the sample-word clock; all sample lanes are timed by it.
// - Device drives a second clock at exactly twice the word clock rate.
// - Ready is high only while the output link can accept sample data.
// - Device reports module errors on a 32-bit signed error word.
// - Config-done rises once converters are configured for the clock mode.
`ifndef DAC_PORT_DEFS_SVH
`define DAC_PORT_DEFS_SVH

`define A_CTRL       8'h00
`define A_TRIM       8'h04
`define A_STAT       8'h08
`define A_IRQ_STAT   8'h0c
`define A_IRQ_MASK   8'h10
`define A_ERR        8'h14
`define A_COUNT      8'h18

`define CTRL_DUAL    0
`define CTRL_ISINC   1
`define CTRL_CLK_EXT 2
`define CTRL_RESTART 3
`define CTRL_LINK_EN 4
`define CTRL_RST     5'h11

`define TRIM_W       12
`define TRIM_MIN     12'h000

`define STAT_READY   0
`define STAT_DONE    1
`define STAT_LINK    2

`define IRQ_DROP     0
`define IRQ_DONE     1
`define IRQ_LOST     2
`define IRQ_W        3

`define ERR_NONE     32'h0000_0000
`define ERR_LOST     32'hffff_ffff
`define ERR_DROP     32'hffff_fffe

`define CFG_TIME_NS  10000
`define CLK_MHZ      40
`define CFG_CYCLES   ((`CFG_TIME_NS * `CLK_MHZ + 999) / 1000)

`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

// [common/dac_port_pkg.sv]
package dac_port_pkg;

	typedef logic signed [11:0] sample_t;

	// Lane 0 is the newest sample, lane 15 the oldest
	typedef sample_t [15:0] lanes_t;

	typedef struct packed {
		lanes_t chan1;
		lanes_t chan0;
	} frame_t;

	typedef struct packed {
		logic link_en;
		logic restart;
		logic clk_ext;
		logic isinc;
		logic dual;
	} ctrl_t;

	typedef enum logic [1:0] {
		CFG_START = 2'b00,
		CFG_WAIT  = 2'b01,
		CFG_DONE  = 2'b10
	} cfg_state_t;

endpackage

// [rtl/word_clock_gen.sv]
`timescale 1ns/1ps
module word_clock_gen (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	output logic      word_clock,
	output logic      double_rate_clock,
	output logic      word_tick
);

	logic [1:0] phase_reg;
	logic [1:0] phase_next;
	logic       tick_reg;
	logic       tick_next;

	// Bit 0 runs at half of aclk, bit 1 at a quarter: exactly two to one
	always_comb begin
		phase_next = phase_reg + 2'h1;
		tick_next  = (phase_reg == 2'h1);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= 2'h0;
			tick_reg  <= 1'b0;
		end else if (ce) begin
			phase_reg <= phase_next;
			tick_reg  <= tick_next;
		end
	end

	assign double_rate_clock = phase_reg[0];
	assign word_clock        = phase_reg[1];
	assign word_tick         = tick_reg;

endmodule

// [sim/sample_source.sv]
`timescale 1ns/1ps
module sample_source (
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire logic            word_clock,
	input  wire logic            double_rate_clock,
	input  wire logic            output_link_ready,
	input  wire logic            run,
	input  wire logic            slow,
	input  wire logic            ignore_ready,
	output logic                 sample_valid,
	output dac_port_pkg::lanes_t chan0_sample_lanes,
	output dac_port_pkg::lanes_t chan1_sample_lanes
);
	logic [7:0] seq_reg;
	logic       alt_reg;
	logic       pre_tick;
	logic       offer;
	// Next cycle is the word tick
	assign pre_tick = !word_clock && double_rate_clock;
	assign offer = run && (output_link_ready || ignore_ready)
		&& (!slow || alt_reg);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_reg <= 8'h00;
			alt_reg <= 1'b0;
			sample_valid <= 1'b0;
			chan0_sample_lanes <= '0;
			chan1_sample_lanes <= '0;
		end else if (pre_tick && offer) begin
			sample_valid <= 1'b1;
			seq_reg <= seq_reg + 8'h01;
			alt_reg <= !alt_reg;
			for (int i = 0; i < 16; i++) begin
				// Lane index in low bits, lane 0 newest
				chan0_sample_lanes[i] <= {seq_reg, 4'(i)};
				chan1_sample_lanes[i] <= {~seq_reg, 4'(i)};
			end
		end else begin
			if (pre_tick)
				alt_reg <= !alt_reg;
			sample_valid <= 1'b0;
			// Lanes keep moving when nothing is offered
			chan0_sample_lanes <= ~chan0_sample_lanes;
			chan1_sample_lanes <= ~chan1_sample_lanes;
		end
	end
endmodule

// [sim/dual_dac_sample_port_bench.sv]
`timescale 1ns/1ps
`include "dac_port_defs.svh"
module dual_dac_sample_port_bench;
	logic                 aclk, aresetn, ce, link_up_pin;
	logic [7:0]           s_axi_awaddr, s_axi_araddr;
	logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic [31:0]          s_axi_wdata, s_axi_rdata, error_word;
	logic [3:0]           s_axi_wstrb;
	logic                 s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic [1:0]           s_axi_bresp, s_axi_rresp;
	logic                 s_axi_arvalid, s_axi_arready;
	logic                 s_axi_rvalid, s_axi_rready;
	logic                 sample_valid, word_clock, double_rate_clock;
	logic                 output_link_ready, config_done, irq;
	logic                 conv_frame_valid, conv_dual_mode;
	logic                 conv_isinc_en, clk_src_ext;
	logic [11:0]          phase_trim;
	dac_port_pkg::lanes_t chan0_sample_lanes, chan1_sample_lanes;
	dac_port_pkg::frame_t conv_frame, pend_f;
	logic                 run, slow, ignore_ready, pend;
	int                   bad_count, comparisons, accepted, wc_n, dr_n;
	int                   wc_0, dr_0;
	logic                 wc_prev, dr_prev;

	dual_dac_sample_port #(.CFG_CYCLES(4)) dut_u (.*);
	sample_source src_u (.*);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = !aclk;
	end

	task automatic check(input logic [383:0] seen, input logic [383:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (bad_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, e);
		check(s_axi_rresp, er);
	endtask

	// Every accepted set must come out whole, one edge later
	always @(posedge aclk) begin
		if (!aresetn) begin
			pend <= 1'b0;
		end else begin
			if (pend) begin
				check(conv_frame_valid, 1'b1);
				check(conv_frame, pend_f);
				check(conv_frame.chan0[0][3:0], 4'h0);
				check(conv_frame.chan1[15][3:0], 4'hf);
				accepted++;
			end else if (conv_frame_valid !== 1'b0) begin
				check(conv_frame_valid, 1'b0);
			end
			pend <= sample_valid && word_clock && !double_rate_clock
				&& output_link_ready && ce;
			pend_f <= {chan1_sample_lanes, chan0_sample_lanes};
		end
	end

	initial begin
		repeat (5000) @(posedge aclk);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		{aresetn, link_up_pin, run, slow, ignore_ready} = '0;
		ce = 1'b1;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge aclk);
		check(conv_dual_mode, 1'b1);
		check(conv_isinc_en, 1'b0);
		check(clk_src_ext, 1'b0);
		check(phase_trim, `TRIM_MIN);
		check(output_link_ready, 1'b0);
		check(error_word, `ERR_NONE);
		aresetn <= 1'b1;
		rd(`A_CTRL, 32'h0000_0011, `RESP_OKAY);
		rd(`A_TRIM, 32'h0000_0000, `RESP_OKAY);
		wc_0 = wc_n;
		dr_0 = dr_n;
		repeat (32) @(posedge aclk);
		check(wc_n - wc_0, 16);
		check(dr_n - dr_0, 32);
		check(config_done, 1'b1);
		rd(`A_STAT, 32'h0000_0002, `RESP_OKAY);
		rd(8'h1c, 32'h0000_0000, `RESP_SLVERR);
		wr(`A_STAT, 32'h0000_0007, `RESP_SLVERR);
		wr(`A_IRQ_MASK, 32'h0000_0007, `RESP_OKAY);
		ignore_ready <= 1'b1;
		run <= 1'b1;
		repeat (8) @(posedge aclk);
		{run, ignore_ready} <= 2'b00;
		repeat (2) @(posedge aclk);
		check(error_word, `ERR_DROP);
		check(irq, 1'b1);
		rd(`A_IRQ_STAT, 32'h0000_0003, `RESP_OKAY);
		wr(`A_IRQ_STAT, 32'h0000_0003, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(irq, 1'b0);
		link_up_pin <= 1'b1;
		run <= 1'b1;
		repeat (40) @(posedge aclk);
		check(output_link_ready, 1'b1);
		slow <= 1'b1;
		repeat (40) @(posedge aclk);
		run <= 1'b0;
		repeat (8) @(posedge aclk);
		check(accepted > 8, 1'b1);
		rd(`A_COUNT, 32'(accepted), `RESP_OKAY);
		link_up_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		check(output_link_ready, 1'b0);
		check(error_word, `ERR_DROP);
		rd(`A_IRQ_STAT, 32'h0000_0004, `RESP_OKAY);
		wr(`A_TRIM, 32'h0000_05a5, `RESP_OKAY);
		wr(`A_CTRL, 32'h0000_0017, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(phase_trim, 12'h5a5);
		check(conv_isinc_en, 1'b1);
		check(clk_src_ext, 1'b1);
		check(config_done, 1'b0);
		wr(`A_CTRL, 32'h0000_0008, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(config_done, 1'b0);
		check(error_word, `ERR_NONE);
		check(conv_isinc_en, 1'b0);
		check(clk_src_ext, 1'b0);
		rd(`A_CTRL, 32'h0000_0011, `RESP_OKAY);
		rd(`A_TRIM, 32'h0000_0000, `RESP_OKAY);
		repeat (10) @(posedge aclk);
		check(config_done, 1'b1);
		check(conv_dual_mode, 1'b1);
		ce <= 1'b0;
		@(posedge aclk);
		dr_0 = dr_n;
		repeat (8) @(posedge aclk);
		check(dr_n - dr_0, 1);
		ce <= 1'b1;
		wr(`A_TRIM, 32'h0000_0123, `RESP_OKAY);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(phase_trim, `TRIM_MIN);
		check(config_done, 1'b0);
		tally_and_finish();
	end

	// Word clock flips every second edge, double rate every edge
	always @(posedge aclk) begin
		wc_prev <= word_clock;
		dr_prev <= double_rate_clock;
		wc_n <= wc_n + int'(word_clock != wc_prev);
		dr_n <= dr_n + int'(double_rate_clock != dr_prev);
	end
endmodule
